// file: hw/jogb_pkg.sv
// Shared constants, register map and state encoding of the jog and external brake logic.
// Assumes a 25 MHz system clock; frequencies are counted in steps of 0.1 Hz.
package jogb_pkg;
    // Timing.
    localparam int CLK_HZ = 25_000_000;
    localparam int DELAY_TICK_MS = 100;
    localparam int DELAY_TICK_CYCLES = (CLK_HZ / 1000) * DELAY_TICK_MS;
    localparam int RAMP_STEP_US = 100;
    localparam int RAMP_STEP_CYCLES = (CLK_HZ / 1_000_000) * RAMP_STEP_US;

    // Limits, in 0.1 Hz, 0.1 s and percent.
    localparam logic [15:0] JOG_FREQ_MAX = 16'h0064;
    localparam logic [5:0] BRAKE_DELAY_MAX = 6'h32;
    localparam logic [6:0] BRAKE_FORCE_MAX = 7'h64;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INPUT_MAP = 8'h04;
    localparam logic [7:0] ADDR_JOG_FREQ = 8'h08;
    localparam logic [7:0] ADDR_START_FREQ = 8'h0C;
    localparam logic [7:0] ADDR_NORMAL_FREQ = 8'h10;
    localparam logic [7:0] ADDR_BRAKE_DELAY = 8'h14;
    localparam logic [7:0] ADDR_BRAKE_FORCE = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;

    // Field positions.
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_STOP_LSB = 2;
    localparam int MAP_FIELD_W = 4;
    localparam int STAT_ON_BIT = 3;
    localparam int STAT_BRAKE_BIT = 4;
    localparam int STAT_COAST_BIT = 5;
    localparam int STAT_JOG_BIT = 6;
    localparam int STAT_IN_LSB = 8;
    localparam int STAT_FREQ_LSB = 16;

    // Reset values.
    localparam logic [1:0] RST_SRC = 2'h1;
    localparam logic [1:0] RST_STOP = 2'h0;
    localparam logic [23:0] RST_INPUT_MAP = 24'hFF7610;
    localparam logic [15:0] RST_JOG_FREQ = 16'h0032;
    localparam logic [15:0] RST_START_FREQ = 16'h0005;
    localparam logic [15:0] RST_NORMAL_FREQ = 16'h01F4;
    localparam logic [5:0] RST_BRAKE_DELAY = 6'h00;
    localparam logic [6:0] RST_BRAKE_FORCE = 7'h00;

    // Codes.
    localparam logic [1:0] SRC_TERMINAL = 2'h1;
    localparam logic [1:0] STOP_COAST = 2'h0;
    localparam logic [1:0] STOP_DECEL = 2'h1;
    localparam logic [1:0] STOP_DC_BRAKE = 2'h2;
    localparam logic [3:0] FUNC_FORWARD = 4'h0;
    localparam logic [3:0] FUNC_REVERSE = 4'h1;
    localparam logic [3:0] FUNC_JOG = 4'h6;
    localparam logic [3:0] FUNC_EXT_BRAKE = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RUN = 3'h1,
        ST_JOG = 3'h2,
        ST_JOG_DECEL = 3'h3,
        ST_JOG_BRAKE = 3'h4,
        ST_BRK_WAIT = 3'h5,
        ST_BRAKE = 3'h6,
        ST_HOLD_OFF = 3'h7
    } jogb_state_t;
endpackage

// file: hw/jogb_tmr_if.sv
// Carrier between the brake sequencer and its delay timer.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface jogb_tmr_if;
    logic run;
    logic [5:0] setting;
    logic done;
    logic [5:0] units;
    modport ctl (output run, output setting, input done, input units);
    modport tmr (input run, input setting, output done, output units);
endinterface : jogb_tmr_if
`default_nettype wire

// file: hw/jogb_sync.sv
// Three-stage input synchroniser with agreement filter for one terminal pin.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module jogb_sync (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Pin and clean level.
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic [2:0] sh;
        logic lvl;
    } jogb_sync_s_t;

    jogb_sync_s_t s_q;
    jogb_sync_s_t s_d;

    // The first stage feeds only the second, so metastability cannot reach the filter.
    always_comb begin
        s_d = s_q;
        s_d.sh = {s_q.sh[1:0], pin_in};
        if (s_q.sh[1] == s_q.sh[2]) begin
            s_d.lvl = s_q.sh[2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.lvl;
endmodule : jogb_sync
`default_nettype wire

// file: hw/jogb_timer.sv
// Brake delay timer counting in steps of 0.1 s.
// Assumes run is held by the sequencer for the whole delay and dropped on release.
`timescale 1ns/1ps
`default_nettype none
module jogb_timer
    import jogb_pkg::*;
#(
    parameter int TICK_CYCLES = DELAY_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Sequencer side.
    jogb_tmr_if.tmr t
);
    localparam int PW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [5:0] units;
    } jogb_tmr_s_t;

    jogb_tmr_s_t s_q;
    jogb_tmr_s_t s_d;

    always_comb begin
        s_d = s_q;
        if (!t.run) begin
            s_d = '0;
        end else if (s_q.pre == PW'(TICK_CYCLES - 1)) begin
            s_d.pre = '0;
            if (s_q.units != 6'h3F) begin
                s_d.units = s_q.units + 6'h01;
            end
        end else begin
            s_d.pre = s_q.pre + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign t.units = s_q.units;
    assign t.done = t.run && (s_q.units >= t.setting);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    tmr_clear_a: assert property (!t.run |=> s_q.units == 6'h00 && s_q.pre == '0)
        else $error("Delay timer not cleared after release.");
    tmr_step_a: assert property (t.run && s_q.pre == PW'(TICK_CYCLES - 1) && s_q.units != 6'h3F
        |=> s_q.units == $past(s_q.units) + 6'h01)
        else $error("Delay timer missed a tick.");
endmodule : jogb_timer
`default_nettype wire

// file: hw/jogb_top.sv
// Jog and external DC brake control: terminal decode, jog run, brake sequencing, registers.
// Assumes terminal pins are asynchronous and the register master is on clk_in.
//
// Behaviour
// - The jog output frequency is clamped to 10 Hz whatever the jog setting holds.
// - The jog target comes from its own stored jog frequency register, apart from normal speed.
// - Jog steps straight to its frequency with no ramp; 5 Hz or less is advised against trips.
// - From idle, with the jog input on and a forward, reverse or (terminal mode only) keypad run on, the jog frequency replaces normal speed.
// - A jog run ends by coasting for code 00, a normal ramp down for 01, or DC braking for 02.
// - Jog is taken from any intelligent input whose function code is 06 and runs while it is on.
// - With the jog input off the block leaves jog operation and stops.
// - No jog starts when the jog setting is zero or below the start frequency.
// - While the external brake input is on, DC injection braking is enabled.
// - The brake delay setting covers 0.0 to 5.0 s in steps of 0.1 s.
// - The brake force setting covers 0 to 100 percent and is the injection strength.
// - Under a terminal run, release of the brake input ramps the output back to its level.
// - Under a keypad run the output stays off after the brake input is released.
// - With a delay the motor coasts first and DC braking starts when the delay expires.
`timescale 1ns/1ps
`default_nettype none
module jogb_top
    import jogb_pkg::*;
#(
    parameter int TICK_CYCLES = DELAY_TICK_CYCLES,
    parameter int RAMP_CYCLES = RAMP_STEP_CYCLES,
    parameter int NUM_INPUTS = 6
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Register port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    // Terminals.
    input wire logic [NUM_INPUTS-1:0] intelligent_in,
    input wire logic keypad_run_in,
    // Drive command.
    output logic [15:0] output_freq_out,
    output logic output_on_out,
    output logic reverse_out,
    output logic dc_brake_out,
    output logic [6:0] brake_force_out,
    output logic coast_out,
    output logic jog_active_out
);
    localparam int RW = $clog2(RAMP_CYCLES + 1);

    typedef struct packed {
        jogb_state_t st;
        logic [15:0] freq;
        logic on;
        logic brake;
        logic coast;
        logic jog_act;
        logic rev;
        logic [6:0] force_o;
        logic [RW-1:0] ramp;
        logic [1:0] src;
        logic [1:0] stop_sel;
        logic [23:0] map;
        logic [15:0] jog_f;
        logic [15:0] start_f;
        logic [15:0] norm_f;
        logic [5:0] dly;
        logic [6:0] force_set;
        logic [31:0] rdata;
    } jogb_top_s_t;

    jogb_top_s_t s_q;
    jogb_top_s_t s_d;

    // True when any input mapped to the given function code is on.
    function automatic logic jogb_func_hit(input logic [23:0] map,
                                           input logic [NUM_INPUTS-1:0] lv,
                                           input logic [3:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (lv[i] && map[i*MAP_FIELD_W +: MAP_FIELD_W] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // One 0.1 Hz step of the ramp toward a target.
    function automatic logic [15:0] jogb_step(input logic [15:0] f, input logic [15:0] tgt);
        if (f < tgt) begin
            return f + 16'h0001;
        end else if (f > tgt) begin
            return f - 16'h0001;
        end
        return f;
    endfunction

    // Synchronised terminals; the keypad run key sits above the intelligent inputs.
    logic [NUM_INPUTS:0] lvl;
    logic [NUM_INPUTS:0] pins;
    assign pins = {keypad_run_in, intelligent_in};

    for (genvar g = 0; g <= NUM_INPUTS; g++) begin : g_sync
        jogb_sync u_sync (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .pin_in(pins[g]),
            .level_out(lvl[g])
        );
    end

    jogb_tmr_if tmr_bus ();

    jogb_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .t(tmr_bus.tmr)
    );

    logic fw_s;
    logic rv_s;
    logic jog_s;
    logic db_s;
    logic kp_s;
    logic terminal;
    logic run_cmd;
    logic jog_run;
    logic jog_ok;
    logic ramp_tick;
    logic [15:0] jog_target;

    assign fw_s = jogb_func_hit(s_q.map, lvl[NUM_INPUTS-1:0], FUNC_FORWARD);
    assign rv_s = jogb_func_hit(s_q.map, lvl[NUM_INPUTS-1:0], FUNC_REVERSE);
    assign jog_s = jogb_func_hit(s_q.map, lvl[NUM_INPUTS-1:0], FUNC_JOG);
    assign db_s = jogb_func_hit(s_q.map, lvl[NUM_INPUTS-1:0], FUNC_EXT_BRAKE);
    assign kp_s = lvl[NUM_INPUTS];
    assign terminal = (s_q.src == SRC_TERMINAL);
    assign run_cmd = terminal ? (fw_s | rv_s) : kp_s;
    // The keypad key counts for jog only in terminal mode.
    assign jog_run = jog_s && (fw_s || rv_s || (terminal && kp_s));
    assign jog_ok = (s_q.jog_f != 16'h0000) && (s_q.jog_f >= s_q.start_f);
    assign jog_target = (s_q.jog_f > JOG_FREQ_MAX) ? JOG_FREQ_MAX : s_q.jog_f;
    assign ramp_tick = (s_q.ramp == RW'(RAMP_CYCLES - 1));

    // The timer runs only in the braking states, so leaving them clears it.
    assign tmr_bus.run = (s_q.st == ST_BRK_WAIT) || (s_q.st == ST_BRAKE)
        || (s_q.st == ST_JOG_BRAKE);
    assign tmr_bus.setting = s_q.dly;

    always_comb begin
        s_d = s_q;
        s_d.ramp = ramp_tick ? '0 : s_q.ramp + {{(RW-1){1'b0}}, 1'b1};
        s_d.rdata = 32'h0000_0000;

        // Register writes; out-of-range brake delay and brake force settings are clamped.
        if (reg_write_in) begin
            case (reg_addr_in)
                ADDR_CTRL: begin
                    s_d.src = reg_wdata_in[CTRL_SRC_LSB +: 2];
                    s_d.stop_sel = reg_wdata_in[CTRL_STOP_LSB +: 2];
                end
                ADDR_INPUT_MAP: s_d.map = reg_wdata_in[23:0];
                ADDR_JOG_FREQ: s_d.jog_f = reg_wdata_in[15:0];
                ADDR_START_FREQ: s_d.start_f = reg_wdata_in[15:0];
                ADDR_NORMAL_FREQ: s_d.norm_f = reg_wdata_in[15:0];
                ADDR_BRAKE_DELAY: begin
                    s_d.dly = (reg_wdata_in[31:0] > 32'(BRAKE_DELAY_MAX)) ? BRAKE_DELAY_MAX
                        : reg_wdata_in[5:0];
                end
                ADDR_BRAKE_FORCE: begin
                    s_d.force_set = (reg_wdata_in[31:0] > 32'(BRAKE_FORCE_MAX))
                        ? BRAKE_FORCE_MAX : reg_wdata_in[6:0];
                end
                default: begin
                end
            endcase
        end

        // Read data stands for exactly the cycle after the strobe.
        if (reg_read_in) begin
            case (reg_addr_in)
                ADDR_CTRL: s_d.rdata = {28'h0000000, s_q.stop_sel, s_q.src};
                ADDR_INPUT_MAP: s_d.rdata = {8'h00, s_q.map};
                ADDR_JOG_FREQ: s_d.rdata = {16'h0000, s_q.jog_f};
                ADDR_START_FREQ: s_d.rdata = {16'h0000, s_q.start_f};
                ADDR_NORMAL_FREQ: s_d.rdata = {16'h0000, s_q.norm_f};
                ADDR_BRAKE_DELAY: s_d.rdata = {26'h0000000, s_q.dly};
                ADDR_BRAKE_FORCE: s_d.rdata = {25'h0000000, s_q.force_set};
                ADDR_STATUS: begin
                    s_d.rdata[2:0] = s_q.st;
                    s_d.rdata[STAT_ON_BIT] = s_q.on;
                    s_d.rdata[STAT_BRAKE_BIT] = s_q.brake;
                    s_d.rdata[STAT_COAST_BIT] = s_q.coast;
                    s_d.rdata[STAT_JOG_BIT] = s_q.jog_act;
                    s_d.rdata[STAT_IN_LSB +: 4] = {kp_s, db_s, jog_s, run_cmd};
                    s_d.rdata[STAT_FREQ_LSB +: 16] = s_q.freq;
                end
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Sequencer.
        case (s_q.st)
            ST_IDLE: begin
                s_d.freq = 16'h0000;
                s_d.on = 1'b0;
                if (db_s) begin
                    s_d.st = ST_BRK_WAIT;
                end else if (jog_run && jog_ok) begin
                    s_d.st = ST_JOG;
                    s_d.freq = jog_target;
                    s_d.on = 1'b1;
                end else if (run_cmd) begin
                    s_d.st = ST_RUN;
                    s_d.on = 1'b1;
                end
            end
            ST_RUN: begin
                if (db_s) begin
                    s_d.st = ST_BRK_WAIT;
                    s_d.freq = 16'h0000;
                    s_d.on = 1'b0;
                end else if (!run_cmd) begin
                    if (s_q.freq == 16'h0000) begin
                        s_d.st = ST_IDLE;
                        s_d.on = 1'b0;
                    end else if (ramp_tick) begin
                        s_d.freq = jogb_step(s_q.freq, 16'h0000);
                    end
                end else if (ramp_tick) begin
                    s_d.freq = jogb_step(s_q.freq, s_q.norm_f);
                end
            end
            ST_JOG: begin
                s_d.freq = jog_target;
                if (db_s) begin
                    s_d.st = ST_BRK_WAIT;
                    s_d.freq = 16'h0000;
                    s_d.on = 1'b0;
                end else if (!jog_run || !jog_ok) begin
                    case (s_q.stop_sel)
                        STOP_DECEL: begin
                            s_d.st = ST_JOG_DECEL;
                            s_d.freq = s_q.freq;
                        end
                        STOP_DC_BRAKE: begin
                            s_d.st = ST_JOG_BRAKE;
                            s_d.freq = 16'h0000;
                            s_d.on = 1'b0;
                        end
                        default: begin
                            s_d.st = ST_IDLE;
                            s_d.freq = 16'h0000;
                            s_d.on = 1'b0;
                        end
                    endcase
                end
            end
            ST_JOG_DECEL: begin
                if (db_s) begin
                    s_d.st = ST_BRK_WAIT;
                    s_d.freq = 16'h0000;
                    s_d.on = 1'b0;
                end else if (s_q.freq == 16'h0000) begin
                    s_d.st = ST_IDLE;
                    s_d.on = 1'b0;
                end else if (ramp_tick) begin
                    s_d.freq = jogb_step(s_q.freq, 16'h0000);
                end
            end
            ST_JOG_BRAKE: begin
                // The jog brake lasts for the brake delay setting.
                if (tmr_bus.done) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_BRK_WAIT, ST_BRAKE: begin
                if (!db_s) begin
                    if (terminal && run_cmd) begin
                        s_d.st = ST_RUN;
                        s_d.on = 1'b1;
                    end else begin
                        s_d.st = ST_HOLD_OFF;
                    end
                end else if (tmr_bus.done) begin
                    s_d.st = ST_BRAKE;
                end
            end
            ST_HOLD_OFF: begin
                s_d.on = 1'b0;
                s_d.freq = 16'h0000;
                if (!run_cmd) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        s_d.brake = (s_d.st == ST_BRAKE) || (s_d.st == ST_JOG_BRAKE);
        s_d.force_o = s_d.brake ? s_d.force_set : 7'h00;
        s_d.coast = (s_d.st == ST_BRK_WAIT);
        s_d.jog_act = (s_d.st == ST_JOG);
        s_d.rev = rv_s && !fw_s;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.src <= RST_SRC;
            s_q.stop_sel <= RST_STOP;
            s_q.map <= RST_INPUT_MAP;
            s_q.jog_f <= RST_JOG_FREQ;
            s_q.start_f <= RST_START_FREQ;
            s_q.norm_f <= RST_NORMAL_FREQ;
            s_q.dly <= RST_BRAKE_DELAY;
            s_q.force_set <= RST_BRAKE_FORCE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_out = s_q.rdata;
    assign output_freq_out = s_q.freq;
    assign output_on_out = s_q.on;
    assign reverse_out = s_q.rev;
    assign dc_brake_out = s_q.brake;
    assign brake_force_out = s_q.force_o;
    assign coast_out = s_q.coast;
    assign jog_active_out = s_q.jog_act;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence brake_released_s;
        s_q.st == ST_BRAKE && !db_s;
    endsequence

    jog_clamp_a: assert property (jog_active_out |-> output_freq_out <= JOG_FREQ_MAX)
        else $error("Jog frequency above the limit.");
    jog_source_a: assert property (s_q.st == ST_JOG && $past(s_q.st == ST_JOG) && !$past(db_s)
        |-> output_freq_out == $past(jog_target))
        else $error("Jog frequency not taken from the jog setting.");
    jog_step_a: assert property ($rose(jog_active_out) |-> output_freq_out == $past(jog_target)
        && output_on_out)
        else $error("Jog did not step straight to its frequency.");
    jog_start_a: assert property (s_q.st == ST_IDLE && !db_s && jog_run && jog_ok
        |=> jog_active_out)
        else $error("Jog did not start on jog input and run.");
    jog_coast_a: assert property (s_q.st == ST_JOG && !db_s && !jog_run
        && s_q.stop_sel == STOP_COAST |=> s_q.st == ST_IDLE && !output_on_out)
        else $error("Jog coast stop failed.");
    jog_off_a: assert property (s_q.st == ST_JOG && !jog_s |=> !jog_active_out)
        else $error("Jog stayed active with the input off.");
    jog_block_a: assert property (s_q.st == ST_IDLE && !jog_ok |=> !jog_active_out)
        else $error("Jog started with an invalid setting.");
    brake_force_a: assert property (s_q.st == ST_BRAKE |-> dc_brake_out
        && brake_force_out == s_q.force_set && !output_on_out)
        else $error("Brake applied without its set force.");
    delay_clamp_a: assert property (s_q.dly <= BRAKE_DELAY_MAX)
        else $error("Brake delay setting out of range.");
    brake_enter_a: assert property ((s_q.st == ST_RUN || s_q.st == ST_IDLE) && db_s
        |=> s_q.st == ST_BRK_WAIT ##1 (s_q.st == ST_BRAKE || coast_out || !db_s))
        else $error("Brake input did not start braking.");
    release_ramp_a: assert property (brake_released_s and terminal && run_cmd
        |=> s_q.st == ST_RUN && output_freq_out == 16'h0000)
        else $error("Terminal run did not resume after brake release.");
    keypad_hold_a: assert property (brake_released_s and !terminal && run_cmd
        |=> s_q.st == ST_HOLD_OFF ##1 !output_on_out)
        else $error("Keypad run output not held off after release.");
    delay_coast_a: assert property (coast_out |-> !dc_brake_out && !output_on_out)
        else $error("Brake applied before the delay expired.");
endmodule : jogb_top
`default_nettype wire

// file: dv/jogb_motor.sv
// Behavioural motor on the drive command of the jog and brake block.
// Assumes the drive command is registered on the same clock.
`timescale 1ns/1ps
`default_nettype none
module jogb_motor (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Drive command.
    input wire logic [15:0] freq_in,
    input wire logic on_in,
    input wire logic brake_in,
    // Shaft speed.
    output logic [15:0] speed_out
);
    // Injection stops the shaft at once; coasting only bleeds speed slowly.
    always_ff @(posedge clk_in) begin
        if (reset_in || brake_in || (!on_in && speed_out == 16'h0000)) begin
            speed_out <= 16'h0000;
        end else begin
            speed_out <= on_in ? freq_in : speed_out - 16'h0001;
        end
    end
endmodule // jogb_motor
`default_nettype wire

// file: dv/jogb_top_tb_top.sv
// Self-checking bench for the jog and external brake block.
// Assumes short timer and ramp parameters so every wait stays brief.
`timescale 1ns/1ps
`default_nettype none
module jogb_top_tb_top;
    import jogb_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [6:0] drv = 7'h00;
    logic [31:0] rdata;
    logic [15:0] freq;
    logic [15:0] speed;
    logic [6:0] force_v;
    logic on, brk, coast, jog, rev;
    logic [4:0] obs;
    int err_total = 0;
    int checks = 0;
    int n;
    assign obs = {freq === 16'h000A, jog, coast, brk, on};
    always #20 clk_in = ~clk_in;
    jogb_top #(.TICK_CYCLES(10), .RAMP_CYCLES(2)) dut (.clk_in(clk_in), .reset_in(reset_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
        .reg_rdata_out(rdata), .intelligent_in(drv[5:0]), .keypad_run_in(drv[6]),
        .output_freq_out(freq), .output_on_out(on), .reverse_out(rev), .dc_brake_out(brk),
        .brake_force_out(force_v), .coast_out(coast), .jog_active_out(jog));
    jogb_motor motor (.clk_in(clk_in), .reset_in(reset_in), .freq_in(freq), .on_in(on),
        .brake_in(brk), .speed_out(speed));
    task automatic report_and_stop();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pin(input int i, input logic v);
        @(posedge clk_in);
        drv[i] <= v;
    endtask
    // Bounded wait on one observed output; running out of bound ends the run.
    task automatic wt(input int sel, input logic v);
        n = 0;
        while (obs[sel] !== v) begin
            @(posedge clk_in);
            #1 n++;
            if (n > 400) begin
                err_total++;
                report_and_stop();
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(ADDR_CTRL, 32'h1);
        rd(ADDR_INPUT_MAP, 32'hFF7610);
        rd(ADDR_JOG_FREQ, 32'h32);
        rd(8'h20, 32'h0);
        wr(ADDR_BRAKE_DELAY, 32'h3F);
        rd(ADDR_BRAKE_DELAY, 32'h32);
        wr(ADDR_BRAKE_DELAY, 32'h0);
        wr(ADDR_JOG_FREQ, 32'hC8);
        pin(6, 1'b1);
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_CTRL, {28'h0, m[1:0], 2'h1});
            pin(2, 1'b1);
            wt(3, 1'b1);
            chk({16'h0, freq}, 32'h64);
            chk({31'h0, on}, 32'h1);
            pin(2, 1'b0);
            if (m == 2) begin
                wt(1, 1'b1);
            end
            wt(0, 1'b0);
            chk({31'h0, n > 100}, {31'h0, m == 1});
            chk({31'h0, jog}, 32'h0);
        end
        wr(ADDR_JOG_FREQ, 32'h0);
        pin(2, 1'b1);
        for (int k = 0; k < 2; k++) begin
            repeat (12) @(posedge clk_in);
            #1 chk({31'h0, jog}, 32'h0);
            wr(ADDR_JOG_FREQ, 32'h4);
        end
        pin(2, 1'b0);
        pin(6, 1'b0);
        wr(ADDR_NORMAL_FREQ, 32'hA);
        wr(ADDR_BRAKE_FORCE, 32'h32);
        pin(1, 1'b1);
        wt(4, 1'b1);
        chk({31'h0, rev}, 32'h1);
        pin(3, 1'b1);
        wt(1, 1'b1);
        chk({25'h0, force_v}, 32'h32);
        chk({31'h0, on}, 32'h0);
        pin(3, 1'b0);
        wt(0, 1'b1);
        chk({31'h0, freq < 16'h000A}, 32'h1);
        wt(4, 1'b1);
        pin(1, 1'b0);
        wt(0, 1'b0);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_BRAKE_DELAY, 32'h3);
        pin(6, 1'b1);
        wt(4, 1'b1);
        pin(3, 1'b1);
        wt(2, 1'b1);
        chk({30'h0, brk, on}, 32'h0);
        wt(1, 1'b1);
        chk({31'h0, n inside {[26:34]}}, 32'h1);
        pin(3, 1'b0);
        repeat (12) @(posedge clk_in);
        #1 chk({31'h0, on}, 32'h0);
        chk({31'h0, rev}, 32'h0);
        chk({16'h0, speed}, 32'h0);
        pin(6, 1'b0);
        report_and_stop();
    end
endmodule // jogb_top_tb_top
`default_nettype wire
